// [rtl/branch_control_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] 0xC6 with address byte loads PC low when accumulator zero; 2 bytes, 2 cycles.
// [RULE2] 0x96 loads PC low byte when accumulator non-zero; 2 bytes, 2 cycles.
// [RULE3] 0x36 branches in page when test input A high; 2 bytes, 2 cycles.
// [RULE4] Branch on test input A low, bits 6..0 = 0100110, with address byte.
// [RULE5] 0x56 branches in page when test input B high; 2 bytes, 2 cycles.
// [RULE6] 0x46 branches in page when test input B low; 2 bytes, 2 cycles.
// [RULE7] 0x16 branches in page when timer overflow flag set; 2 bytes, 2 cycles.
// [RULE8] 0x05 enables external interrupt recognition; one byte, one cycle.
// [RULE9] 0x15 disables external interrupt recognition; one byte, one cycle.
// [RULE10] 0x75 drives the internal clock onto test pin A.
// [RULE11] 0xE5 clears program bank flag, lower bank 0 to 2047.
// [RULE12] 0xF5 sets program bank flag, upper bank 2048 to 4095.
// [RULE13] 0xC5 clears register bank select, registers at locations 0 to 7.
// [RULE14] 0xD5 sets register bank select, registers at locations 24 to 31.
// [RULE15] After bus latch output, bus stays output until reset or external move.
// [RULE16] Instructions are one or two bytes and one or two machine cycles.
// [RULE17] Immediate-operand and input/output instructions take two machine cycles.
// [RULE18] Indirect accesses use pointer register zero or one of selected bank.
// [RULE19] Internal data memory transfer one cycle, external data memory two.
// [RULE20] Accumulator move into status word updates it, stack pointer included.
// [RULE21] Direct moves between accumulator and timer, accumulator and status word.
// [RULE22] Program memory constants load into accumulator or any working register.
// [RULE23] Unconditional jump takes PC bit 11 from program bank flag.
// [RULE24] Clock out is oscillator divided by three, cleared only by reset.
// [RULE25] Branch on test input A low has bit 7 zero, opcode 0x26.
// [RULE26] One machine cycle spans fifteen oscillator periods.
module branch_control_decoder (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    output logic [11:0] prog_addr_o,
    input wire logic [7:0] prog_data_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] timer_i,
    input wire logic timer_overflow_flag_i,
    input wire logic test_input_a_i,
    output logic test_input_a_o,
    output logic test_input_a_oe_o,
    input wire logic test_input_b_i,
    output branch_control_pkg::write_port_s write_port_o,
    output branch_control_pkg::data_access_s data_access_o,
    output logic [7:0] processor_status_word_o,
    output logic [2:0] stack_pointer_o,
    output logic program_bank_flag_o,
    output logic register_bank_select_o,
    output logic ext_irq_enable_o,
    output logic bus_output_mode_o,
    output logic cycle_end_o,
    output logic instr_start_o
);
    import branch_control_pkg::*;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic op_class_s classify(input logic [7:0] op);
        op_class_s c;
        c.two_byte = 1'b0;
        c.two_cycle = 1'b0;
        // Conditional jumps on x6, accumulator bit jumps, jump/call, count loops
        if (op[3:0] == 4'h6 && op != 8'h06 && op != 8'h66 && op != 8'hA6
            && op != 8'hD6)
            c.two_byte = 1'b1;
        if (op[4:0] == 5'h12 || op[3:0] == 4'h4 || op[7:3] == 5'h1D)
            c.two_byte = 1'b1;
        // Immediate operands
        if (op == 8'h03 || op == 8'h13 || op == OP_MOVE_ACC_IMMEDIATE
            || op == 8'h43 || op == 8'h53 || op == 8'hD3
            || op[7:3] == OP_MOVE_REG_IMMEDIATE_HI || op[7:1] == 7'h58
            || op[7:2] == 6'h22 || op[7:2] == 6'h26)
            c.two_byte = 1'b1;
        // Input/output, external moves, returns, program memory reads
        if (op == OP_BUS_LATCH_OUTPUT || op[7:2] == 6'h02 || op[7:1] == 7'h1C
            || op[7:2] == 6'h03 || op[7:2] == 6'h0F || op[7:2] == 6'h23
            || op[7:2] == 6'h27 || op == 8'h83 || op == 8'h93
            || op == 8'hA3 || op == 8'hB3 || op == 8'hE3
            || (op[7:5] == OP_EXT_MOVE_HI && op[3:1] == 3'h0))
            c.two_cycle = 1'b1;
        if (c.two_byte)
            c.two_cycle = 1'b1; // RULE17
        return c;
    endfunction

    function automatic logic [4:0] reg_location(input logic bank, input logic [2:0] r);
        reg_location = (bank ? REG_BANK_HIGH_BASE : REG_BANK_LOW_BASE) + {2'b00, r};
    endfunction

    function automatic logic is_indirect(input logic [7:0] op);
        is_indirect = op[3:1] == 3'h0 && (op[7:4] == 4'h1 || op[7:4] == 4'h2
            || op[7:4] == 4'h3 || op[7:4] == 4'h4 || op[7:4] == 4'h5
            || op[7:4] == 4'h6 || op[7:4] == 4'h7 || op[7:4] == 4'h8
            || op[7:4] == 4'h9 || op[7:4] == 4'hA || op[7:4] == 4'hB
            || op[7:4] == 4'hD || op[7:4] == 4'hF);
    endfunction

    // ----------------------------------------------------------------
    // Timing: machine cycle and clock output divider
    // ----------------------------------------------------------------
    logic [3:0] slot_r, slot_nxt;
    logic [1:0] div_r, div_nxt;
    logic clk_out_r, clk_out_nxt;
    logic cycle_end;

    always_comb begin
        cycle_end = slot_r == MCYCLE_LAST;
        slot_nxt = cycle_end ? 4'h0 : slot_r + 4'h1; // RULE26
        div_nxt = (div_r == CLKOUT_LAST) ? 2'h0 : div_r + 2'h1; // RULE24
        clk_out_nxt = div_nxt == 2'h0;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slot_r <= 4'h0;
            div_r <= 2'h0;
            clk_out_r <= 1'b0;
        end else begin
            slot_r <= slot_nxt;
            div_r <= div_nxt;
            clk_out_r <= clk_out_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Execution control
    // ----------------------------------------------------------------
    exec_state_e state_r, state_nxt;
    logic [11:0] pc_r, pc_nxt;
    logic [7:0] op_r, op_nxt;
    logic [7:0] psw_r, psw_nxt;
    logic bank_flag_r, bank_flag_nxt;
    logic irq_en_r, irq_en_nxt;
    logic clk_en_r, clk_en_nxt;
    logic bus_out_r, bus_out_nxt;
    write_port_s wr_r, wr_nxt;
    data_access_s acc_r, acc_nxt;
    logic start_r, start_nxt;

    logic [7:0] op;
    logic [11:0] pc_inc;
    op_class_s cls;
    logic take;
    logic exec;

    always_comb begin
        op = (state_r == ST_OPCODE) ? prog_data_i : op_r;
        cls = classify(op);
        pc_inc = {pc_r[11], pc_r[10:0] + 11'h001};
        state_nxt = state_r;
        pc_nxt = pc_r;
        op_nxt = op_r;
        psw_nxt = psw_r;
        bank_flag_nxt = bank_flag_r;
        irq_en_nxt = irq_en_r;
        clk_en_nxt = clk_en_r;
        bus_out_nxt = bus_out_r;
        wr_nxt = '0;
        wr_nxt.acc_wdata = wr_r.acc_wdata;
        wr_nxt.reg_addr = wr_r.reg_addr;
        wr_nxt.reg_wdata = wr_r.reg_wdata;
        wr_nxt.timer_wdata = wr_r.timer_wdata;
        acc_nxt = acc_r;
        acc_nxt.indirect = 1'b0;
        acc_nxt.external = 1'b0;
        start_nxt = 1'b0;
        take = 1'b0;
        exec = 1'b0;
        if (cycle_end) begin
            case (state_r)
                ST_OPCODE: begin
                    op_nxt = prog_data_i;
                    pc_nxt = pc_inc;
                    start_nxt = 1'b1;
                    if (cls.two_byte)
                        state_nxt = ST_OPERAND; // RULE16
                    else if (cls.two_cycle)
                        state_nxt = ST_SECOND;
                    else
                        exec = 1'b1;
                end
                ST_OPERAND: begin
                    state_nxt = ST_OPCODE;
                    pc_nxt = pc_inc;
                    case (op)
                        OP_BRANCH_IF_ACC_ZERO: take = acc_i == 8'h00; // RULE1
                        OP_BRANCH_IF_ACC_NONZERO: take = acc_i != 8'h00; // RULE2
                        OP_BRANCH_IF_TEST_A_HIGH: take = test_input_a_i; // RULE3
                        OP_BRANCH_IF_TEST_A_LOW: take = !test_input_a_i; // RULE4 RULE25
                        OP_BRANCH_IF_TEST_B_HIGH: take = test_input_b_i; // RULE5
                        OP_BRANCH_IF_TEST_B_LOW: take = !test_input_b_i; // RULE6
                        OP_BRANCH_IF_TIMER_OVERFLOW: take = timer_overflow_flag_i; // RULE7
                        OP_BRANCH_IF_CARRY: take = psw_r[PSW_CARRY_BIT];
                        OP_BRANCH_IF_NO_CARRY: take = !psw_r[PSW_CARRY_BIT];
                        OP_MOVE_ACC_IMMEDIATE: begin
                            wr_nxt.acc_we = 1'b1; // RULE22
                            wr_nxt.acc_wdata = prog_data_i;
                        end
                        default: begin
                            if (op[4:0] == OP_UNCOND_JUMP_LO || op[4:0] == OP_CALL_LO)
                                pc_nxt = {bank_flag_r, op[7:5], prog_data_i}; // RULE23
                            if (op[7:3] == OP_MOVE_REG_IMMEDIATE_HI) begin
                                wr_nxt.reg_we = 1'b1; // RULE22
                                wr_nxt.reg_addr = reg_location(psw_r[PSW_BANK_BIT], op[2:0]);
                                wr_nxt.reg_wdata = prog_data_i;
                            end
                        end
                    endcase
                    if (take)
                        pc_nxt = {pc_r[11:8], prog_data_i};
                end
                ST_SECOND: begin
                    state_nxt = ST_OPCODE;
                    exec = 1'b1; // RULE19
                end
                default: state_nxt = ST_OPCODE;
            endcase
        end
        if (exec) begin
            case (op)
                OP_EXT_IRQ_ENABLE: irq_en_nxt = 1'b1; // RULE8
                OP_EXT_IRQ_DISABLE: irq_en_nxt = 1'b0; // RULE9
                OP_CLOCK_OUT_ENABLE: clk_en_nxt = 1'b1; // RULE10
                OP_PROGRAM_BANK_LOW: bank_flag_nxt = 1'b0; // RULE11
                OP_PROGRAM_BANK_HIGH: bank_flag_nxt = 1'b1; // RULE12
                OP_REGISTER_BANK_LOW: psw_nxt[PSW_BANK_BIT] = 1'b0; // RULE13
                OP_REGISTER_BANK_HIGH: psw_nxt[PSW_BANK_BIT] = 1'b1; // RULE14
                OP_BUS_LATCH_OUTPUT: bus_out_nxt = 1'b1; // RULE15
                OP_MOVE_PSW_FROM_ACC: psw_nxt = acc_i; // RULE20
                OP_MOVE_ACC_FROM_PSW: begin
                    wr_nxt.acc_we = 1'b1; // RULE21
                    wr_nxt.acc_wdata = psw_r;
                end
                OP_MOVE_TIMER_FROM_ACC: begin
                    wr_nxt.timer_we = 1'b1; // RULE21
                    wr_nxt.timer_wdata = acc_i;
                end
                OP_MOVE_ACC_FROM_TIMER: begin
                    wr_nxt.acc_we = 1'b1; // RULE21
                    wr_nxt.acc_wdata = timer_i;
                end
                default: begin
                    if (is_indirect(op)) begin
                        acc_nxt.indirect = 1'b1; // RULE18
                        acc_nxt.external = op[7:5] == OP_EXT_MOVE_HI;
                        acc_nxt.pointer_addr = reg_location(psw_r[PSW_BANK_BIT], {2'b00, op[0]});
                        if (op[7:5] == OP_EXT_MOVE_HI)
                            bus_out_nxt = 1'b0; // RULE15
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= ST_OPCODE;
            pc_r <= PC_RESET;
            op_r <= 8'h00;
            psw_r <= PSW_RESET;
            bank_flag_r <= 1'b0;
            irq_en_r <= 1'b0;
            clk_en_r <= 1'b0; // RULE24
            bus_out_r <= 1'b0;
            wr_r <= '0;
            acc_r <= '0;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            op_r <= op_nxt;
            psw_r <= psw_nxt;
            bank_flag_r <= bank_flag_nxt;
            irq_en_r <= irq_en_nxt;
            clk_en_r <= clk_en_nxt;
            bus_out_r <= bus_out_nxt;
            wr_r <= wr_nxt;
            acc_r <= acc_nxt;
            start_r <= start_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prog_addr_o = pc_r;
    assign test_input_a_o = clk_out_r;
    assign test_input_a_oe_o = clk_en_r;
    assign write_port_o = wr_r;
    assign data_access_o = acc_r;
    assign processor_status_word_o = psw_r;
    assign stack_pointer_o = psw_r[2:0];
    assign program_bank_flag_o = bank_flag_r;
    assign register_bank_select_o = psw_r[PSW_BANK_BIT];
    assign ext_irq_enable_o = irq_en_r;
    assign bus_output_mode_o = bus_out_r;
    assign cycle_end_o = cycle_end;
    assign instr_start_o = start_r;

endmodule
`default_nettype wire

// [rtl/branch_control_pkg.sv]
package branch_control_pkg;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_BRANCH_IF_ACC_ZERO = 8'hC6;
    localparam logic [7:0] OP_BRANCH_IF_ACC_NONZERO = 8'h96;
    localparam logic [7:0] OP_BRANCH_IF_TEST_A_HIGH = 8'h36;
    localparam logic [7:0] OP_BRANCH_IF_TEST_A_LOW = 8'h26;
    localparam logic [7:0] OP_BRANCH_IF_TEST_B_HIGH = 8'h56;
    localparam logic [7:0] OP_BRANCH_IF_TEST_B_LOW = 8'h46;
    localparam logic [7:0] OP_BRANCH_IF_TIMER_OVERFLOW = 8'h16;
    localparam logic [7:0] OP_BRANCH_IF_CARRY = 8'hF6;
    localparam logic [7:0] OP_BRANCH_IF_NO_CARRY = 8'hE6;
    localparam logic [7:0] OP_EXT_IRQ_ENABLE = 8'h05;
    localparam logic [7:0] OP_EXT_IRQ_DISABLE = 8'h15;
    localparam logic [7:0] OP_CLOCK_OUT_ENABLE = 8'h75;
    localparam logic [7:0] OP_PROGRAM_BANK_LOW = 8'hE5;
    localparam logic [7:0] OP_PROGRAM_BANK_HIGH = 8'hF5;
    localparam logic [7:0] OP_REGISTER_BANK_LOW = 8'hC5;
    localparam logic [7:0] OP_REGISTER_BANK_HIGH = 8'hD5;
    localparam logic [7:0] OP_BUS_LATCH_OUTPUT = 8'h02;
    localparam logic [7:0] OP_MOVE_PSW_FROM_ACC = 8'hD7;
    localparam logic [7:0] OP_MOVE_ACC_FROM_PSW = 8'hC7;
    localparam logic [7:0] OP_MOVE_TIMER_FROM_ACC = 8'h62;
    localparam logic [7:0] OP_MOVE_ACC_FROM_TIMER = 8'h42;
    localparam logic [7:0] OP_MOVE_ACC_IMMEDIATE = 8'h23;
    // Working register immediate load: upper five bits, low three pick the register
    localparam logic [4:0] OP_MOVE_REG_IMMEDIATE_HI = 5'h17;
    // External data move: bits 7..5 = 100, bits 3..1 = 000
    localparam logic [2:0] OP_EXT_MOVE_HI = 3'h4;
    // Unconditional jump and call: bits 4..0
    localparam logic [4:0] OP_UNCOND_JUMP_LO = 5'h04;
    localparam logic [4:0] OP_CALL_LO = 5'h14;

    // ----------------------------------------------------------------
    // Field positions, reset values, timing
    // ----------------------------------------------------------------
    localparam int PSW_CARRY_BIT = 7;
    localparam int PSW_BANK_BIT = 4;
    localparam logic [7:0] PSW_RESET = 8'h08;
    localparam logic [4:0] REG_BANK_LOW_BASE = 5'h00;
    localparam logic [4:0] REG_BANK_HIGH_BASE = 5'h18;
    localparam logic [11:0] PC_RESET = 12'h000;
    // Oscillator periods per machine cycle and per output clock period
    localparam int OSC_PER_MCYCLE = 15;
    localparam int OSC_PER_CLKOUT = 3;
    localparam logic [3:0] MCYCLE_LAST = 4'(OSC_PER_MCYCLE - 1);
    localparam logic [1:0] CLKOUT_LAST = 2'(OSC_PER_CLKOUT - 1);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_OPCODE, ST_OPERAND, ST_SECOND} exec_state_e;

    typedef struct packed {
        logic two_byte;
        logic two_cycle;
    } op_class_s;

    typedef struct packed {
        logic acc_we;
        logic [7:0] acc_wdata;
        logic reg_we;
        logic [4:0] reg_addr;
        logic [7:0] reg_wdata;
        logic timer_we;
        logic [7:0] timer_wdata;
    } write_port_s;

    typedef struct packed {
        logic indirect;
        logic external;
        logic [4:0] pointer_addr;
    } data_access_s;

endpackage

// [testbench/branch_control_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module branch_control_checker (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [11:0] prog_addr_o,
    input wire logic [7:0] prog_data_i,
    input wire logic test_input_a_o,
    input wire logic test_input_a_oe_o,
    input wire branch_control_pkg::write_port_s write_port_o,
    input wire branch_control_pkg::data_access_s data_access_o,
    input wire logic [7:0] processor_status_word_o,
    input wire logic [2:0] stack_pointer_o,
    input wire logic program_bank_flag_o,
    input wire logic register_bank_select_o,
    input wire logic ext_irq_enable_o,
    input wire logic cycle_end_o,
    input wire logic instr_start_o
);
    import branch_control_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    mcycle_len_a: assert property (cycle_end_o |-> ##15 cycle_end_o)
        else $error("machine cycle length wrong");
    mcycle_gap_a: assert property (cycle_end_o |=> !cycle_end_o [*8])
        else $error("cycle end too soon");
    pc_update_a: assert property ($changed(prog_addr_o) |-> $past(cycle_end_o))
        else $error("pc moved off a cycle end");
    start_edge_a: assert property (instr_start_o |-> $past(cycle_end_o))
        else $error("start pulse off a cycle end");
    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    irq_on_a: assert property ($rose(ext_irq_enable_o) |->
        $past(prog_data_i) == OP_EXT_IRQ_ENABLE)
        else $error("irq enable without its opcode");
    irq_off_a: assert property ($fell(ext_irq_enable_o) |->
        $past(prog_data_i) == OP_EXT_IRQ_DISABLE)
        else $error("irq disable without its opcode");
    bank_high_a: assert property ($rose(program_bank_flag_o) |->
        $past(prog_data_i) == OP_PROGRAM_BANK_HIGH)
        else $error("bank flag set without its opcode");
    bank_low_a: assert property ($fell(program_bank_flag_o) |->
        $past(prog_data_i) == OP_PROGRAM_BANK_LOW)
        else $error("bank flag cleared without its opcode");
    pc_bank_a: assert property ($changed(prog_addr_o[11]) |->
        prog_addr_o[11] == program_bank_flag_o)
        else $error("pc bit 11 not from bank flag");
    psw_fields_a: assert property ($changed({processor_status_word_o[7:5],
        processor_status_word_o[3], stack_pointer_o}) |->
        $past(cycle_end_o) && $past(prog_data_i) == OP_MOVE_PSW_FROM_ACC)
        else $error("status word changed without a move");
    reg_bank_a: assert property (write_port_o.reg_we |->
        write_port_o.reg_addr[4:3] == {2{register_bank_select_o}})
        else $error("register write outside bank");
    pointer_bank_a: assert property (data_access_o.indirect |->
        data_access_o.pointer_addr[4:1] == {{2{register_bank_select_o}}, 2'b00})
        else $error("pointer not in selected bank");
    clk_keep_a: assert property (!$fell(test_input_a_oe_o))
        else $error("clock output dropped");
    clk_div_a: assert property (test_input_a_oe_o && test_input_a_o |=>
        !test_input_a_o ##1 !test_input_a_o ##1 test_input_a_o)
        else $error("clock output not divide by three");
    cover property ($rose(test_input_a_oe_o));
    cover property (write_port_o.reg_we);
    cover property (data_access_o.external);
endmodule
bind branch_control_decoder branch_control_checker checker_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .prog_addr_o(prog_addr_o),
    .prog_data_i(prog_data_i), .test_input_a_o(test_input_a_o),
    .test_input_a_oe_o(test_input_a_oe_o), .write_port_o(write_port_o),
    .data_access_o(data_access_o), .processor_status_word_o(processor_status_word_o),
    .stack_pointer_o(stack_pointer_o), .program_bank_flag_o(program_bank_flag_o),
    .register_bank_select_o(register_bank_select_o), .ext_irq_enable_o(ext_irq_enable_o),
    .cycle_end_o(cycle_end_o), .instr_start_o(instr_start_o)
);
`default_nettype wire

// [testbench/branch_control_decoder_test.sv]
`timescale 1ns/1ps
`default_nettype none
module branch_control_decoder_test;
    import branch_control_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] acc_i = 8'h00;
    logic [7:0] timer_i = 8'h00;
    logic tf_i = 1'b0;
    logic ta_i = 1'b0;
    logic tb_i = 1'b0;
    logic [11:0] pc;
    logic ta_o, ta_oe, pbf, rbs, irq, bom, ce, ist;
    logic [7:0] processor_status_word;
    logic [2:0] sp;
    write_port_s wp;
    data_access_s da;
    logic [7:0] rom [4096];
    wire [7:0] prog_data;
    wire ta_pin;
    int bad_count = 0;
    int compares = 0;
    assign prog_data = rom[pc];
    assign ta_pin = ta_oe ? ta_o : ta_i;
    always #2.5 sys_clk_i = ~sys_clk_i;
    branch_control_decoder uut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .prog_addr_o(pc),
        .prog_data_i(prog_data), .acc_i(acc_i), .timer_i(timer_i),
        .timer_overflow_flag_i(tf_i), .test_input_a_i(ta_pin), .test_input_a_o(ta_o),
        .test_input_a_oe_o(ta_oe), .test_input_b_i(tb_i), .write_port_o(wp),
        .data_access_o(da), .processor_status_word_o(processor_status_word), .stack_pointer_o(sp),
        .program_bank_flag_o(pbf), .register_bank_select_o(rbs), .ext_irq_enable_o(irq),
        .bus_output_mode_o(bom), .cycle_end_o(ce), .instr_start_o(ist)
    );
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic fail(input logic [11:0] got, input logic [11:0] exp);
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) fail({11'h000, got}, {11'h000, exp});
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) fail({4'h0, got}, {4'h0, exp});
    endtask
    task automatic chk_pc(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) fail(got, exp);
    endtask
    task automatic boot();
        @(negedge sys_clk_i);
        sys_rst_i = 1'b1;
        repeat (12) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
    endtask
    // Ends at the falling edge after the n-th taken cycle end
    task automatic wait_mc(input int n);
        repeat (n) begin
            while (ce !== 1'b1) @(negedge sys_clk_i);
            @(negedge sys_clk_i);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_branches();
        logic [7:0] ops [7] = '{OP_BRANCH_IF_ACC_ZERO, OP_BRANCH_IF_ACC_NONZERO,
            OP_BRANCH_IF_TEST_A_HIGH, OP_BRANCH_IF_TEST_A_LOW, OP_BRANCH_IF_TEST_B_HIGH,
            OP_BRANCH_IF_TEST_B_LOW, OP_BRANCH_IF_TIMER_OVERFLOW};
        logic t;
        for (int i = 0; i < 14; i++) begin
            t = i[0];
            acc_i = 8'h00;
            ta_i = 1'b0;
            tb_i = 1'b0;
            tf_i = 1'b0;
            case (i / 2)
                0: acc_i = t ? 8'h00 : 8'h01;
                1: acc_i = t ? 8'h80 : 8'h00;
                2: ta_i = t;
                3: ta_i = !t;
                4: tb_i = t;
                5: tb_i = !t;
                default: tf_i = t;
            endcase
            rom[0] = ops[i / 2];
            rom[1] = 8'h4C;
            boot();
            wait_mc(1);
            chk_pc(pc, 12'h001);
            wait_mc(1);
            chk_pc(pc, t ? 12'h04C : 12'h002);
        end
        $display("test branches done");
    endtask
    task automatic test_controls();
        logic [11:0] cnt;
        rom[0] = 8'h05;
        rom[1] = 8'h15;
        rom[2] = 8'hF5;
        rom[3] = 8'h04;
        rom[4] = 8'h10;
        rom[12'h810] = 8'hD5;
        rom[12'h811] = 8'hC5;
        rom[12'h812] = 8'hE5;
        rom[12'h813] = 8'h75;
        rom[12'h814] = 8'h04;
        rom[12'h815] = 8'h20;
        boot();
        chk_bit(irq, 1'b0);
        wait_mc(1);
        chk_bit(irq, 1'b1);
        chk_bit(ist, 1'b1);
        wait_mc(1);
        chk_bit(irq, 1'b0);
        wait_mc(1);
        chk_bit(pbf, 1'b1);
        chk_pc(pc, 12'h003);
        wait_mc(2);
        chk_pc(pc, 12'h810);
        wait_mc(1);
        chk_bit(rbs, 1'b1);
        wait_mc(1);
        chk_bit(rbs, 1'b0);
        wait_mc(1);
        chk_bit(pbf, 1'b0);
        chk_pc(pc, 12'h813);
        chk_bit(ta_oe, 1'b0);
        wait_mc(1);
        chk_bit(ta_oe, 1'b1);
        wait_mc(2);
        chk_pc(pc, 12'h020);
        cnt = 12'h000;
        repeat (9) begin
            @(negedge sys_clk_i);
            cnt = cnt + {11'h000, ta_pin};
        end
        chk_pc(cnt, 12'h003);
        chk_bit(ta_oe, 1'b1);
        $display("test controls done");
    endtask
    task automatic test_moves();
        rom[0] = 8'hD7;
        rom[1] = 8'hC7;
        rom[2] = 8'h23;
        rom[3] = 8'h3C;
        rom[4] = 8'hBF;
        rom[5] = 8'h77;
        rom[6] = 8'h62;
        rom[7] = 8'h42;
        rom[8] = 8'h02;
        rom[9] = 8'h80;
        rom[10] = 8'hF6;
        rom[11] = 8'h40;
        rom[12] = 8'hE6;
        rom[13] = 8'h44;
        acc_i = 8'h5B;
        timer_i = 8'h99;
        boot();
        wait_mc(1);
        chk_byte(processor_status_word, 8'h5B);
        chk_byte({5'h00, sp}, 8'h03);
        wait_mc(1);
        chk_bit(wp.acc_we, 1'b1);
        chk_byte(wp.acc_wdata, 8'h5B);
        wait_mc(1);
        chk_bit(wp.acc_we, 1'b0);
        wait_mc(1);
        chk_byte(wp.acc_wdata, 8'h3C);
        wait_mc(2);
        chk_bit(wp.reg_we, 1'b1);
        chk_byte({3'h0, wp.reg_addr}, 8'h1F);
        chk_byte(wp.reg_wdata, 8'h77);
        wait_mc(1);
        chk_byte(wp.timer_wdata, 8'h5B);
        chk_bit(wp.timer_we, 1'b1);
        wait_mc(1);
        chk_byte(wp.acc_wdata, 8'h99);
        wait_mc(1);
        chk_bit(bom, 1'b0);
        wait_mc(1);
        chk_bit(bom, 1'b1);
        wait_mc(1);
        chk_bit(da.indirect, 1'b0);
        wait_mc(1);
        chk_bit(da.external, 1'b1);
        chk_byte({3'h0, da.pointer_addr}, 8'h18);
        chk_bit(bom, 1'b0);
        wait_mc(2);
        chk_pc(pc, 12'h00C);
        wait_mc(2);
        chk_pc(pc, 12'h044);
        $display("test moves done");
    endtask
    initial begin
        foreach (rom[i]) rom[i] = 8'h00;
        test_branches();
        test_controls();
        test_moves();
        wrap_up();
    end
    initial begin
        #50000;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
